// ---- hdl/cct_pkg.sv ----
// constants of the capture/compare timer: register map, field positions, reset values
package cct_pkg;

    // register byte offsets on the avalon slave
    localparam logic [4:0] off_count_value   = 5'h00;
    localparam logic [4:0] off_cc_reg_a      = 5'h04;
    localparam logic [4:0] off_cc_reg_b      = 5'h08;
    localparam logic [4:0] off_mode_control  = 5'h0c;
    localparam logic [4:0] off_prescaler     = 5'h10;
    localparam logic [4:0] off_cc_control    = 5'h14;
    localparam logic [4:0] off_out_control   = 5'h18;

    // timer_mode_control fields
    localparam int mode_ovf_bit  = 0;
    localparam int mode_sel_lo   = 2;
    localparam int mode_sel_hi   = 3;

    // prescaler_mode fields
    localparam int presc_div_lo  = 0;
    localparam int presc_ea_lo   = 4;
    localparam int presc_eb_lo   = 6;

    // capture/compare control fields
    localparam int cc_a_capture  = 0;
    localparam int cc_b_capture  = 1;

    // output control fields
    localparam int oc_pin1_out   = 0;
    localparam int oc_tout_en    = 1;
    localparam int oc_one_shot   = 2;

    typedef enum logic [1:0] {
        cct_mode_stop,
        cct_mode_free,
        cct_mode_clr_edge,
        cct_mode_clr_match
    } cct_mode_t;

    // edge select codes
    localparam logic [1:0] edge_fall = 2'h0;
    localparam logic [1:0] edge_rise = 2'h1;
    localparam logic [1:0] edge_both = 2'h2;

    localparam logic [15:0] count_max   = 16'hffff;
    localparam logic [15:0] count_zero  = 16'h0000;
    localparam logic [15:0] cc_reset    = 16'h0000;
    localparam logic [7:0]  div_reset   = 8'h00;
    localparam logic [31:0] rd_unmapped = 32'h0000_0000;

endpackage : cct_pkg

// ---- hdl/cct_sync.sv ----
// three-stage input synchroniser with agreement filter and edge pulses
`timescale 1ns/1ns
`default_nettype none
module cct_sync (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic rise;
        logic fall;
        logic [1:0] fill;
    } cct_sync_t;

    cct_sync_t st_r;
    cct_sync_t st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.s1   = pin_in;
        st_nxt.s2   = st_r.s1;
        st_nxt.s3   = st_r.s2;
        st_nxt.rise = 1'b0;
        st_nxt.fall = 1'b0;
        // only s2 and s3 are compared, s1 stays private
        if (st_r.fill != 2'h3) begin
            // priming: adopt the idle level silently, no false edge after reset
            st_nxt.fill = st_r.fill + 2'h1;
            st_nxt.lvl  = st_r.s2;
        end else if (st_r.s2 == st_r.s3 && st_r.s3 != st_r.lvl) begin
            st_nxt.lvl  = st_r.s3;
            st_nxt.rise = st_r.s3;
            st_nxt.fall = ~st_r.s3;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.lvl;
    assign rise  = st_r.rise;
    assign fall  = st_r.fall;
endmodule : cct_sync
`default_nettype wire

// ---- hdl/cct_timer.sv ----
// 16-bit capture/compare timer with avalon-mm register slave
//
// What this block does
// - with reg a at zero in free or clear-on-edge mode, match_irq_a fires on the 0000H to 0001H step after wrap.
// - with reg a at zero, match_irq_a also fires on a match, a capture_input_b edge and a one-shot clear.
// - shared_port_pin_1 is either capture_input_b or timer_output, never both.
// - a reg a capture colliding with a read or a stop gives a loose read or stored value only.
// - with reg b at zero, match_irq_b fires on the 0000H to 0001H step, a match, a capture_input_a edge and a one-shot clear.
// - a reg b capture colliding with a read or a stop gives a loose read or stored value only.
// - capture_compare_reg_b accepts writes while the counter runs.
// - the counter runs whenever the mode select bits are not both zero and stops when they are.
// - the active edge of capture_input_a comes from prescaler_mode.
// - a count wrap from FFFFH to 0000H sets overflow_flag.
//
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module cct_timer (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        shared_port_pin_0,
    input  wire logic        pin1_in,
    output logic             pin1_out,
    output logic             pin1_oe,
    output logic             timer_output,
    output logic             match_irq_a,
    output logic             match_irq_b
);
    typedef struct packed {
        logic [15:0]       count;
        logic [15:0]       cr_a;
        logic [15:0]       cr_b;
        cct_pkg::cct_mode_t mode;
        logic              ovf;
        logic [1:0]        div_sel;
        logic [1:0]        edge_a_sel;
        logic [1:0]        edge_b_sel;
        logic [7:0]        div_cnt;
        logic              cap_a;
        logic              cap_b;
        logic              pin1_sel;
        logic              tout_en;
        logic              tout;
        logic              irq_a;
        logic              irq_b;
        logic              wait_n;
        logic [31:0]       rdata;
    } cct_state_t;

    cct_state_t st_r;
    cct_state_t st_nxt;

    logic in_a_lvl;
    logic in_a_rise;
    logic in_a_fall;
    logic in_b_lvl;
    logic in_b_rise;
    logic in_b_fall;

    cct_sync u_sync_a (
        .clock  (clock),
        .reset  (reset),
        .pin_in (shared_port_pin_0),
        .level  (in_a_lvl),
        .rise   (in_a_rise),
        .fall   (in_a_fall)
    );

    cct_sync u_sync_b (
        .clock  (clock),
        .reset  (reset),
        .pin_in (pin1_in),
        .level  (in_b_lvl),
        .rise   (in_b_rise),
        .fall   (in_b_fall)
    );

    function automatic logic cct_valid_edge(input logic [1:0] sel,
                                            input logic rise,
                                            input logic fall);
        case (sel)
            cct_pkg::edge_fall: cct_valid_edge = fall;
            cct_pkg::edge_rise: cct_valid_edge = rise;
            cct_pkg::edge_both: cct_valid_edge = rise | fall;
            default:            cct_valid_edge = 1'b0;
        endcase
    endfunction : cct_valid_edge

    function automatic logic [15:0] cct_merge16(input logic [15:0] old,
                                                input logic [31:0] wd,
                                                input logic [3:0]  be);
        cct_merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : cct_merge16

    logic        running;
    logic        tick;
    logic        edge_a;
    logic        edge_b;
    logic        match_a;
    logic        match_b;
    logic        wrap;
    logic        clr_cnt;
    logic        wr_go;
    logic        one_shot;
    logic        ovf_set;

    always_comb begin
        running  = st_r.mode != cct_pkg::cct_mode_stop;
        tick     = running && ((st_r.div_cnt & ((8'h01 << st_r.div_sel) - 8'h01)) == 8'h00);
        edge_a   = cct_valid_edge(st_r.edge_a_sel, in_a_rise, in_a_fall);
        // input b ignored while pin drives
        edge_b   = !st_r.pin1_sel && cct_valid_edge(st_r.edge_b_sel, in_b_rise, in_b_fall);
        match_a  = tick && st_r.count == st_r.cr_a;
        match_b  = tick && st_r.count == st_r.cr_b;
        wr_go    = avs_write && !st_r.wait_n;
        one_shot = wr_go && avs_address == cct_pkg::off_out_control && avs_byteenable[0]
                   && avs_writedata[cct_pkg::oc_one_shot] && running;
        clr_cnt  = one_shot
                   || (st_r.mode == cct_pkg::cct_mode_clr_edge && edge_a)
                   || (st_r.mode == cct_pkg::cct_mode_clr_match && match_a && !st_r.cap_a);
        wrap     = tick && !clr_cnt && st_r.count == cct_pkg::count_max;
        ovf_set  = wrap;
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.irq_a = 1'b0;
        st_nxt.irq_b = 1'b0;
        st_nxt.div_cnt = running ? st_r.div_cnt + 8'h01 : cct_pkg::div_reset;

        if (!running) begin
            st_nxt.count = cct_pkg::count_zero;
        end else if (clr_cnt) begin
            st_nxt.count = cct_pkg::count_zero;
        end else if (tick) begin
            st_nxt.count = st_r.count + 16'h0001;
        end

        // zero compare fires on 0000H to 0001H
        // zero compare also on edge b and one-shot
        if (!st_r.cap_a && (match_a || (st_r.cr_a == cct_pkg::cc_reset && (edge_b || one_shot)))) begin
            st_nxt.irq_a = running;
        end
        if (!st_r.cap_b && (match_b || (st_r.cr_b == cct_pkg::cc_reset && (edge_a || one_shot)))) begin
            st_nxt.irq_b = running;
        end

        // capture uses the live count, also on a stopping edge
        if (st_r.cap_a && edge_b) begin
            st_nxt.cr_a = st_r.count;
        end
        // capture b from the live count
        if (st_r.cap_b && edge_a) begin
            st_nxt.cr_b = st_r.count;
        end

        if (st_r.tout_en && running && match_a && !st_r.cap_a) begin
            st_nxt.tout = ~st_r.tout;
        end

        // bus: one wait cycle, then answer
        if ((avs_read || avs_write) && st_r.wait_n) begin
            st_nxt.wait_n = 1'b0;
            case (avs_address)
                cct_pkg::off_count_value:  st_nxt.rdata = {16'h0000, st_r.count};
                // read during capture returns the older word
                cct_pkg::off_cc_reg_a:     st_nxt.rdata = {16'h0000, st_r.cr_a};
                cct_pkg::off_cc_reg_b:     st_nxt.rdata = {16'h0000, st_r.cr_b};
                cct_pkg::off_mode_control: st_nxt.rdata = {28'h000_0000, st_r.mode, 1'b0, st_r.ovf};
                cct_pkg::off_prescaler:    st_nxt.rdata = {24'h00_0000, st_r.edge_b_sel,
                                                           st_r.edge_a_sel, 2'h0, st_r.div_sel};
                cct_pkg::off_cc_control:   st_nxt.rdata = {30'h0000_0000, st_r.cap_b, st_r.cap_a};
                cct_pkg::off_out_control:  st_nxt.rdata = {29'h0000_0000, 1'b0, st_r.tout_en,
                                                           st_r.pin1_sel};
                default:                   st_nxt.rdata = cct_pkg::rd_unmapped;
            endcase
        end else if (!st_r.wait_n) begin
            st_nxt.wait_n = 1'b1;
        end

        if (wr_go) begin
            case (avs_address)
                // reg a write taken as is, software keeps it still while running
                cct_pkg::off_cc_reg_a: begin
                    st_nxt.cr_a = cct_merge16(st_r.cr_a, avs_writedata, avs_byteenable);
                end
                cct_pkg::off_cc_reg_b: begin
                    st_nxt.cr_b = cct_merge16(st_r.cr_b, avs_writedata, avs_byteenable);
                end
                // mode bits taken as written, software stops first
                cct_pkg::off_mode_control: begin
                    if (avs_byteenable[0]) begin
                        st_nxt.mode = cct_pkg::cct_mode_t'(avs_writedata[cct_pkg::mode_sel_hi:
                                                                           cct_pkg::mode_sel_lo]);
                        st_nxt.ovf  = avs_writedata[cct_pkg::mode_ovf_bit];
                    end
                end
                cct_pkg::off_prescaler: begin
                    if (avs_byteenable[0]) begin
                        st_nxt.div_sel    = avs_writedata[cct_pkg::presc_div_lo +: 2];
                        st_nxt.edge_a_sel = avs_writedata[cct_pkg::presc_ea_lo +: 2];
                        st_nxt.edge_b_sel = avs_writedata[cct_pkg::presc_eb_lo +: 2];
                    end
                end
                cct_pkg::off_cc_control: begin
                    if (avs_byteenable[0]) begin
                        st_nxt.cap_a = avs_writedata[cct_pkg::cc_a_capture];
                        st_nxt.cap_b = avs_writedata[cct_pkg::cc_b_capture];
                    end
                end
                cct_pkg::off_out_control: begin
                    if (avs_byteenable[0]) begin
                        st_nxt.pin1_sel = avs_writedata[cct_pkg::oc_pin1_out];
                        st_nxt.tout_en  = avs_writedata[cct_pkg::oc_tout_en];
                    end
                end
                default: begin
                end
            endcase
        end

        // set wins over a clearing write
        if (ovf_set) begin
            st_nxt.ovf = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st_r         <= '0;
            st_r.mode    <= cct_pkg::cct_mode_stop;
            st_r.cr_a    <= cct_pkg::cc_reset;
            st_r.cr_b    <= cct_pkg::cc_reset;
            st_r.div_cnt <= cct_pkg::div_reset;
            st_r.wait_n  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avs_readdata    = st_r.rdata;
    assign avs_waitrequest = st_r.wait_n;
    assign match_irq_a     = st_r.irq_a;
    assign match_irq_b     = st_r.irq_b;
    assign timer_output    = st_r.tout;
    // pin drives only when chosen as output
    assign pin1_oe         = st_r.pin1_sel;
    assign pin1_out        = st_r.tout;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_bus_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence

    sequence s_bus_ans;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    chk_bus_answer: assert property (s_bus_req |=> s_bus_ans)
        else $error("bus answer not one cycle after request");

    chk_stop_clears: assert property (
        st_r.mode == cct_pkg::cct_mode_stop |=> st_r.count == cct_pkg::count_zero)
        else $error("counter not held at zero in stop mode");

    chk_count_step: assert property (
        tick && !clr_cnt |=> st_r.count == $past(st_r.count) + 16'h0001)
        else $error("counter did not step on count clock");

    chk_ovf_wrap: assert property (
        tick && !clr_cnt && st_r.count == cct_pkg::count_max
        |=> st_r.ovf && st_r.count == cct_pkg::count_zero)
        else $error("wrap did not set overflow flag");

    chk_irq_a_zero: assert property (
        running && tick && !st_r.cap_a && st_r.cr_a == cct_pkg::cc_reset
        && st_r.count == cct_pkg::count_zero |=> match_irq_a ##1 !match_irq_a)
        else $error("zero compare a missed the 0000H step");

    chk_irq_a_edge: assert property (
        running && edge_b && !st_r.cap_a && st_r.cr_a == cct_pkg::cc_reset |=> match_irq_a)
        else $error("edge b did not raise match a with zero compare");

    chk_pin_excl: assert property (
        pin1_oe && running && st_r.cr_a == cct_pkg::cc_reset && !match_a && !one_shot
        |=> !match_irq_a)
        else $error("input b edge seen while pin drives output");

    chk_cap_b_take: assert property (
        st_r.cap_b && edge_a && !wr_go |=> st_r.cr_b == $past(st_r.count))
        else $error("reg b capture missed");

    chk_irq_b_zero: assert property (
        running && !st_r.cap_b && st_r.cr_b == cct_pkg::cc_reset && (edge_a || match_b)
        |=> match_irq_b)
        else $error("zero compare b did not raise match b");

    chk_wr_b_run: assert property (
        running && wr_go && avs_address == cct_pkg::off_cc_reg_b && avs_byteenable[1:0] == 2'h3
        && !(st_r.cap_b && edge_a) |=> st_r.cr_b == $past(avs_writedata[15:0]))
        else $error("reg b write lost while running");

    chk_edge_sel: assert property (
        st_r.edge_a_sel == cct_pkg::edge_rise && in_a_fall |-> !edge_a)
        else $error("falling edge a accepted under rising select");

    chk_read_cap: assert property (
        s_bus_req ##0 (avs_address == cct_pkg::off_cc_reg_a)
        |=> avs_readdata[15:0] == $past(st_r.cr_a))
        else $error("reg a read word wrong");

    chk_cap_a_take: assert property (
        st_r.cap_a && edge_b && !wr_go |=> st_r.cr_a == $past(st_r.count))
        else $error("reg a capture missed");

    chk_tout_toggle: assert property (
        st_r.tout_en && match_a && !st_r.cap_a |=> timer_output != $past(timer_output))
        else $error("timer output did not toggle on match");

    chk_one_shot_clr: assert property (
        one_shot |=> st_r.count == cct_pkg::count_zero)
        else $error("one-shot did not clear the counter");

    chk_clr_on_match: assert property (
        st_r.mode == cct_pkg::cct_mode_clr_match && match_a && !st_r.cap_a
        |=> st_r.count == cct_pkg::count_zero)
        else $error("clear on match missed");

    chk_ovf_set_wins: assert property (
        ovf_set |=> st_r.ovf)
        else $error("overflow set lost to a write");

    chk_irq_b_pulse: assert property (
        match_irq_b && !match_b && !edge_a && !one_shot |=> !match_irq_b)
        else $error("match b pulse longer than one cycle");

endmodule : cct_timer
`default_nettype wire

// ---- testbench/cct_pin_model.sv ----
// partner model: drives both capture pins and resolves the shared pin
`timescale 1ns/1ns
`default_nettype none
module cct_pin_model (
    input  wire logic clock,
    input  wire logic pin1_out,
    input  wire logic pin1_oe,
    output logic      pin_a,
    output logic      pin_b
);
    logic drv_a = 1'b1;
    logic drv_b = 1'b1;

    assign pin_a = drv_a;
    assign pin_b = pin1_oe ? pin1_out : drv_b;

    // level held 10 cycles, well past the 3-cycle filter
    task automatic drive(input bit sel_b, input logic v);
        @(posedge clock);
        if (sel_b) drv_b <= v;
        else drv_a <= v;
        repeat (9) @(posedge clock);
    endtask : drive

    task automatic pulse(input bit sel_b);
        drive(sel_b, 1'b0);
        drive(sel_b, 1'b1);
    endtask : pulse
endmodule : cct_pin_model
`default_nettype wire

// ---- testbench/cct_timer_tb.sv ----
// self-checking bench of the capture/compare timer
`timescale 1ns/1ns
`default_nettype none
module cct_timer_tb;
    logic        clock          = 1'b0;
    logic        reset          = 1'b1;
    logic [4:0]  avs_address    = 5'h00;
    logic        avs_read       = 1'b0;
    logic        avs_write      = 1'b0;
    logic [31:0] avs_writedata  = 32'h0000_0000;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        pin_a;
    logic        pin_b;
    logic        pin1_out;
    logic        pin1_oe;
    logic        timer_output;
    logic        match_irq_a;
    logic        match_irq_b;
    int          bad_count  = 0;
    int          n_compared = 0;
    int          cyc = 0, na = 0, nb = 0, tb_last = 0, tb_prev = 0;
    int          n, m;
    int          nt = 0, ta_last = 0, ta_prev = 0, dv;
    logic        tout_q = 1'b0;
    logic [31:0] q, v;

    always #5 clock = ~clock;

    cct_timer dut (
        .clock(clock), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .shared_port_pin_0(pin_a),
        .pin1_in(pin_b), .pin1_out(pin1_out), .pin1_oe(pin1_oe),
        .timer_output(timer_output), .match_irq_a(match_irq_a), .match_irq_b(match_irq_b)
    );

    cct_pin_model partner (
        .clock(clock), .pin1_out(pin1_out), .pin1_oe(pin1_oe), .pin_a(pin_a), .pin_b(pin_b)
    );

    // pulse counters; irq b times kept for the wrap interval
    always @(posedge clock) begin
        cyc <= cyc + 1;
        tout_q <= timer_output;
        if (timer_output !== tout_q) nt <= nt + 1;
        if (match_irq_a === 1'b1) begin
            na      <= na + 1;
            ta_prev <= ta_last;
            ta_last <= cyc;
        end
        if (match_irq_b === 1'b1) begin
            nb      <= nb + 1;
            tb_prev <= tb_last;
            tb_last <= cyc;
        end
    end

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clock);
        avs_read       <= !w;
        avs_write      <= w;
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= 4'hf;
        do begin
            @(posedge clock);
            t++;
        end while (avs_waitrequest !== 1'b0 && t < 100);
        q = avs_readdata;
        if (t >= 100) chk(1, 0, "bus answer missing");
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] e, input string msg);
        bus(1'b0, a, 32'h0000_0000);
        chk(q, e, msg);
    endtask : rd_chk

    function automatic logic [31:0] mode_w(input logic [1:0] md);
        return 32'(md) << cct_pkg::mode_sel_lo;
    endfunction : mode_w

    function automatic int edges_for(input logic [1:0] e);
        return (e == cct_pkg::edge_both) ? 2 : ((e == 2'h3) ? 0 : 1);
    endfunction : edges_for

    // count clock is clock / 2^div
    function automatic int wrap_period(input int div);
        return 65536 << div;
    endfunction : wrap_period

    function automatic logic [31:0] ok(input logic c);
        return {31'h0000_0000, c};
    endfunction : ok

    initial begin
        void'($urandom(32'ha2c1));
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        for (int i = 0; i < 8; i++) rd_chk(5'(i * 4), 32'h0000_0000, "reset value");
        for (int i = 0; i < 4; i++) begin
            v = {16'h0000, 16'($urandom)};
            bus(1'b1, cct_pkg::off_cc_reg_a, v);
            rd_chk(cct_pkg::off_cc_reg_a, v, "reg a readback");
            bus(1'b1, cct_pkg::off_cc_reg_b, ~v);
            rd_chk(cct_pkg::off_cc_reg_b, {16'h0000, ~v[15:0]}, "reg b readback");
        end
        bus(1'b1, 5'h1c, 32'hffff_ffff);
        rd_chk(5'h1c, 32'h0000_0000, "unmapped read");
        repeat (20) @(posedge clock);
        rd_chk(cct_pkg::off_count_value, 32'h0000_0000, "count moved in stop");
        bus(1'b1, cct_pkg::off_cc_reg_a, 32'h0000_ffff);
        bus(1'b1, cct_pkg::off_cc_reg_b, 32'h0000_0000);
        n = nb;
        bus(1'b1, cct_pkg::off_mode_control, mode_w(cct_pkg::cct_mode_free));
        bus(1'b0, cct_pkg::off_count_value, 32'h0000_0000);
        chk(ok(q[15:0] != 16'h0000), 32'h0000_0001, "count not started");
        for (int t = 0; t < 70000 && nb < n + 2; t++) @(posedge clock);
        chk(tb_last - tb_prev, wrap_period(0), "irq b wrap interval");
        chk(ok(na > 0), 32'h0000_0001, "no irq a on ffff match");
        rd_chk(cct_pkg::off_mode_control, mode_w(cct_pkg::cct_mode_free) | 32'h0000_0001,
               "overflow flag");
        v = {16'h0000, 16'($urandom)};
        bus(1'b1, cct_pkg::off_cc_reg_b, v);
        rd_chk(cct_pkg::off_cc_reg_b, v, "reg b write while running");
        bus(1'b1, cct_pkg::off_mode_control, 32'h0000_0000);
        rd_chk(cct_pkg::off_count_value, 32'h0000_0000, "count after stop");
        bus(1'b1, cct_pkg::off_cc_reg_a, 32'h0000_0000);
        bus(1'b1, cct_pkg::off_cc_reg_b, 32'h0000_0000);
        for (int e = 0; e < 4; e++) begin
            bus(1'b1, cct_pkg::off_prescaler, 32'(e) << cct_pkg::presc_ea_lo);
            bus(1'b1, cct_pkg::off_mode_control, mode_w(cct_pkg::cct_mode_free));
            repeat (50) @(posedge clock);
            n = nb;
            partner.pulse(1'b0);
            repeat (10) @(posedge clock);
            chk(nb - n, edges_for(2'(e)), "input a edge select");
            n = na;
            partner.pulse(1'b1);
            repeat (10) @(posedge clock);
            chk(na - n, 1, "input b edge irq a");
            bus(1'b1, cct_pkg::off_mode_control, 32'h0000_0000);
        end
        bus(1'b1, cct_pkg::off_prescaler, 32'h0000_0000);
        n = na;
        bus(1'b1, cct_pkg::off_mode_control, mode_w(cct_pkg::cct_mode_clr_edge));
        repeat (300) @(posedge clock);
        chk(ok(na > n), 32'h0000_0001, "irq a on zero step");
        partner.pulse(1'b0);
        bus(1'b0, cct_pkg::off_count_value, 32'h0000_0000);
        chk(ok(q[15:0] < 16'h0028), 32'h0000_0001, "clear on input a edge");
        repeat (300) @(posedge clock);
        n = na;
        m = nb;
        bus(1'b1, cct_pkg::off_out_control, 32'h0000_0001 << cct_pkg::oc_one_shot);
        repeat (10) @(posedge clock);
        chk(ok(na > n), 32'h0000_0001, "one-shot irq a");
        chk(ok(nb > m), 32'h0000_0001, "one-shot irq b");
        bus(1'b0, cct_pkg::off_count_value, 32'h0000_0000);
        chk(ok(q[15:0] < 16'h0028), 32'h0000_0001, "one-shot clear");
        rd_chk(cct_pkg::off_out_control, 32'h0000_0000, "one-shot reads zero");
        bus(1'b1, cct_pkg::off_mode_control, 32'h0000_0000);
        bus(1'b1, cct_pkg::off_cc_control, 32'h0000_0003);
        bus(1'b1, cct_pkg::off_prescaler, 32'h0000_0050);
        bus(1'b1, cct_pkg::off_mode_control, mode_w(cct_pkg::cct_mode_free));
        for (int s = 0; s < 2; s++) begin
            repeat (50) @(posedge clock);
            partner.pulse(s[0]);
            bus(1'b0, s ? cct_pkg::off_cc_reg_a : cct_pkg::off_cc_reg_b, 32'h0000_0000);
            v = q;
            bus(1'b0, cct_pkg::off_count_value, 32'h0000_0000);
            chk(ok(q - v > 5 && q - v < 16), 32'h0000_0001, "capture lag");
        end
        bus(1'b1, cct_pkg::off_mode_control, 32'h0000_0000);
        bus(1'b1, cct_pkg::off_cc_control, 32'h0000_0000);
        // reg a nonzero in clear-on-match mode
        v  = {24'h00_0000, 8'($urandom) | 8'h10};
        dv = $urandom % 4;
        bus(1'b1, cct_pkg::off_cc_reg_a, v);
        bus(1'b1, cct_pkg::off_prescaler, 32'(dv));
        bus(1'b1, cct_pkg::off_out_control, 32'h0000_0001 << cct_pkg::oc_tout_en);
        n = na;
        m = nt;
        bus(1'b1, cct_pkg::off_mode_control, mode_w(cct_pkg::cct_mode_clr_match));
        for (int t = 0; t < 9000 && na < n + 3; t++) @(posedge clock);
        chk(ta_last - ta_prev, (v + 1) << dv, "clear on match period");
        chk(nt - m, na - n, "timer output toggles");
        bus(1'b1, cct_pkg::off_mode_control, 32'h0000_0000);
        bus(1'b1, cct_pkg::off_cc_reg_a, 32'h0000_0000);
        bus(1'b1, cct_pkg::off_mode_control, 32'h0000_0000);
        bus(1'b1, cct_pkg::off_out_control, 32'h0000_0001 << cct_pkg::oc_pin1_out);
        n = na;
        bus(1'b1, cct_pkg::off_mode_control, mode_w(cct_pkg::cct_mode_free));
        chk(ok(pin1_oe === 1'b1), 32'h0000_0001, "pin1 not output");
        repeat (50) @(posedge clock);
        partner.pulse(1'b1);
        repeat (10) @(posedge clock);
        // only the zero-compare start step may count
        chk(na - n, 1, "input b live while output");
        bus(1'b1, cct_pkg::off_mode_control, 32'h0000_0000);
        bus(1'b1, cct_pkg::off_out_control, 32'h0000_0000);
        @(posedge clock);
        chk(ok(pin1_oe === 1'b0), 32'h0000_0001, "pin1 still output");
        print_verdict();
    end

    // run needs at most about 74k cycles
    initial begin
        repeat (100000) @(posedge clock);
        chk(1, 0, "watchdog expired");
        print_verdict();
    end
endmodule : cct_timer_tb
`default_nettype wire
